// >>> ncwt_core.v
// codeword transfer sequencer with apb registers and ecc status capture
`timescale 1ns/1ps
`default_nettype none
`include "ncwt_map.vh"
// Function
// R1: seed status bit 5 reads 1 once seed ecc status is valid
// R2: seed status bits 4:3 give seed bit error count
// R3: seed status bits 2,1,0 are fail, done and error-found flags
// R4: 16 status registers hold 32 codeword statuses, first has ready bit
// R5: control bit 19 writes each codeword status beside spare; software uses stride 8
// R6: spare register a/b serve buffer 0/1: supply on encode, capture on decode
// R7: master config bit 2 picks slave (0) or bus master (1) transfer
// R8: slave mode software fills/fetches buffers itself; master registers ignored
// R9: slave mode codeword count from control bits 6:5, at most 2
// R10: master mode codeword count from control bits 27:22, at most 32
// R11: control bit 20 goes high when transfer completes, either mode
// R12: master mode software programs both start addresses before operation
// R13: master mode page and spare regions contiguous, stepped per codeword
// R14: page stride 1024 unless managed and half select, then 512
// R15: spare stride 4 when bit 19 clear, 8 when set
// R16: raw device: ecc control bit 16 picks 1024 or 512 byte codeword
// R17: full codeword moves and codes 1024 page bytes plus spare
// R18: half codeword moves 512 bytes, ecc still on 1024 unit
// R19: half mode software pads first 512 bytes with 0xff
// R20: randomizer not allowed in half codeword mode
// R21: managed device: control bit 21 picks 1024 or 512 byte codeword
// R22: flash pins: two chip selects, latches, strobes, 8-bit data, ready
// R23: bit 11 clear means raw using ecc bit 16, set means managed using bit 21
// R24: done flag cleared when a new transfer starts
module ncwt_core
(
  // apb slave
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  // ecc engine results, one pulse per codeword
  input  wire        ecc_valid,
  input  wire [15:0] ecc_status,
  input  wire        seed_valid,
  input  wire [1:0]  seed_err_cnt,
  input  wire        seed_fail,
  input  wire        seed_errf,
  // per codeword handshake from the flash byte engine
  input  wire        cw_done,
  input  wire [7:0]  flash_data_in,
  input  wire        flash_dqs_in,
  input  wire        flash_rdy,
  // flash pins
  output reg         chip_select0_n,
  output reg         chip_select1_n,
  output reg         flash_ale,
  output reg         flash_cle,
  output reg         flash_wrn,
  output reg         flash_rdn,
  output reg  [7:0]  flash_data_out,
  output reg         flash_data_oe,
  output reg         flash_dqs_out,
  output reg         flash_dqs_oe,
  // codeword engine controls
  output reg         cw_start,
  output reg  [10:0] cw_page_bytes,
  output reg         cw_half_pad,
  output reg  [31:0] cw_page_addr,
  output reg  [31:0] cw_spare_addr,
  output reg         cw_master,
  output reg         cw_buf_sel,
  output reg  [31:0] cw_spare_tx,
  output reg         cw_status_wr,
  output reg         rand_active
);

  localparam [2:0] ST_IDLE = 3'b001;
  localparam [2:0] ST_RUN  = 3'b010;
  localparam [2:0] ST_WAIT = 3'b100;

  reg [31:0] flash_control_reg;
  reg [31:0] ecc_control_reg;
  reg [31:0] master_transfer_config;
  reg [31:0] page_region_start;
  reg [31:0] spare_region_start;
  reg [31:0] spare_buffer_a;
  reg [31:0] spare_buffer_b;
  reg [31:0] rand_cfg_reg;
  reg [5:0]  seed_st_reg;
  reg [15:0] cw_status_mem [0:31];
  reg        status_ready_reg;
  reg [2:0]  state_reg;
  reg [5:0]  cw_total_reg;
  reg [5:0]  cw_idx_reg;
  reg [31:0] rdata_next;
  integer    i;

  // writes commit on the edge that ends the access, with pready high;
  // read data is latched one edge earlier so it stands when pready is seen
  wire wr_en = psel & penable & pwrite & pready;
  wire rd_en = psel & penable & ~pwrite & ~pready;
  wire start_req = wr_en && paddr == `NCWT_OFF_FLASH_CONTROL_REG && pwdata[`NCWT_FL_START];
  wire is_status = paddr >= `NCWT_OFF_BCHST0 && paddr <= `NCWT_OFF_BCHST15;
  wire op_busy = state_reg != ST_IDLE;

  // effective half codeword: managed uses bit 21, raw uses ecc bit 16
  function half_sel;
    input [31:0] fl;
    input [31:0] bc;
    begin
      half_sel = fl[`NCWT_FL_MANAGED] ? fl[`NCWT_FL_HALF] : bc[`NCWT_BCH_HALF]; // R16 R21 R23
    end
  endfunction

  // page stride halves only with managed device select and half select bit 21
  function [31:0] page_stride;
    input [31:0] fl;
    begin
      if (fl[`NCWT_FL_MANAGED] && fl[`NCWT_FL_HALF]) // R14
        page_stride = `NCWT_UNIT_HALF;
      else
        page_stride = `NCWT_UNIT_FULL;
    end
  endfunction

  function [31:0] spare_stride;
    input [31:0] fl;
    begin
      spare_stride = fl[`NCWT_FL_STXFER] ? `NCWT_SPARE_STRIDE_WIDE : `NCWT_SPARE_STRIDE_NARROW; // R15 R5
    end
  endfunction

  // status word number from byte address; base is not on a 64-byte boundary
  function [3:0] status_word;
    input [11:0] a;
    reg   [11:0] rel;
    begin
      rel         = a - `NCWT_OFF_BCHST0;
      status_word = rel[5:2];
    end
  endfunction

  always @*
  begin
    rdata_next = 32'h0000_0000;
    if (is_status && paddr[1:0] == 2'b00)
    begin
      // two codewords per word; first word also carries ready
      rdata_next = {cw_status_mem[{status_word(paddr), 1'b1}],
                    cw_status_mem[{status_word(paddr), 1'b0}]}; // R4
      if (paddr == `NCWT_OFF_BCHST0)
        rdata_next[`NCWT_BCHST_RDY] = status_ready_reg; // R4
    end
    else
    begin
      case (paddr)
        `NCWT_OFF_FLASH_CONTROL_REG:      rdata_next = flash_control_reg;
        `NCWT_OFF_ECC_CONTROL_REG:     rdata_next = ecc_control_reg;
        `NCWT_OFF_MTCFG:      rdata_next = master_transfer_config;
        `NCWT_OFF_PAGE_ADDR:  rdata_next = page_region_start;
        `NCWT_OFF_SPARE_ADDR: rdata_next = spare_region_start;
        `NCWT_OFF_CUR_PAGE:   rdata_next = cw_page_addr;
        `NCWT_OFF_CUR_SPARE:  rdata_next = cw_spare_addr;
        `NCWT_OFF_SPARE_A:    rdata_next = spare_buffer_a;
        `NCWT_OFF_SPARE_B:    rdata_next = spare_buffer_b;
        `NCWT_OFF_RAND_CFG:   rdata_next = rand_cfg_reg;
        `NCWT_OFF_SEED_ST:    rdata_next = {26'h0, seed_st_reg}; // R1 R2 R3
        default:              rdata_next = 32'h0000_0000;
      endcase
    end
  end

  wire addr_known = is_status ||
                    paddr <= `NCWT_OFF_CUR_SPARE ||
                    (paddr >= `NCWT_OFF_SPARE_A && paddr <= `NCWT_OFF_SEED_ST);

  // apb: one wait state, pready pulses in the second access cycle
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end
    else
    begin
      pready  <= psel & penable & ~pready;
      pslverr <= psel & penable & ~pready & ~(addr_known && paddr[1:0] == 2'b00);
      if (rd_en)
        prdata <= rdata_next;
    end
  end

  // software registers and sequencer
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      flash_control_reg      <= 32'h0000_0000;
      ecc_control_reg        <= 32'h0000_0000;
      master_transfer_config <= 32'h0000_0000;
      page_region_start      <= 32'h0000_0000;
      spare_region_start     <= 32'h0000_0000;
      spare_buffer_a         <= `NCWT_SPARE_RESET;
      spare_buffer_b         <= `NCWT_SPARE_RESET;
      rand_cfg_reg           <= 32'h0000_0000;
      seed_st_reg            <= 6'h00;
      status_ready_reg       <= 1'b0;
      state_reg              <= ST_IDLE;
      cw_total_reg           <= 6'h00;
      cw_idx_reg             <= 6'h00;
      cw_start               <= 1'b0;
      cw_page_bytes          <= 11'h400;
      cw_half_pad            <= 1'b0;
      cw_page_addr           <= 32'h0000_0000;
      cw_spare_addr          <= 32'h0000_0000;
      cw_master              <= 1'b0;
      cw_buf_sel             <= 1'b0;
      cw_spare_tx            <= 32'h0000_0000;
      cw_status_wr           <= 1'b0;
      rand_active            <= 1'b0;
      for (i = 0; i < 32; i = i + 1)
        cw_status_mem[i] <= 16'h0000;
    end
    else
    begin
      cw_start     <= 1'b0;
      cw_status_wr <= 1'b0;
      if (wr_en)
      begin
        case (paddr)
          `NCWT_OFF_FLASH_CONTROL_REG:
          begin
            // done bit is hardware owned; start self clears
            flash_control_reg <= {pwdata[31:21], 1'b0, pwdata[19:1], 1'b0}; // R24
          end
          `NCWT_OFF_ECC_CONTROL_REG:     ecc_control_reg <= pwdata;
          `NCWT_OFF_MTCFG:      master_transfer_config <= pwdata;
          `NCWT_OFF_PAGE_ADDR:  page_region_start <= pwdata;
          `NCWT_OFF_SPARE_ADDR: spare_region_start <= pwdata;
          `NCWT_OFF_SPARE_A:    spare_buffer_a <= pwdata;
          `NCWT_OFF_SPARE_B:    spare_buffer_b <= pwdata;
          `NCWT_OFF_RAND_CFG:   rand_cfg_reg <= pwdata;
          default:              ;
        endcase
      end
      // seed decode result; flags are read only and replaced per seed
      if (seed_valid)
        seed_st_reg <= {1'b1, seed_err_cnt, seed_fail, 1'b1, seed_errf}; // R1 R2 R3
      case (state_reg)
        ST_IDLE:
        begin
          if (start_req && state_reg == ST_IDLE)
          begin
            state_reg        <= ST_RUN;
            cw_idx_reg       <= 6'h00;
            status_ready_reg <= 1'b0;
            seed_st_reg      <= 6'h00;
            cw_master        <= master_transfer_config[`NCWT_MT_MASTER]; // R7
            if (master_transfer_config[`NCWT_MT_MASTER])
            begin
              // zero field means the full 32 codewords
              cw_total_reg  <= pwdata[27:22] == 6'h00 ? 6'h1F : pwdata[27:22] - 6'h01; // R10
              cw_page_addr  <= page_region_start; // R13
              cw_spare_addr <= spare_region_start; // R13
            end
            else
            begin
              // slave mode limited to the two internal buffers
              cw_total_reg  <= pwdata[6:5] >= 2'b10 ? 6'h01 : 6'h00; // R9 R8
              cw_page_addr  <= 32'h0000_0000;
              cw_spare_addr <= 32'h0000_0000;
            end
          end
        end
        ST_RUN:
        begin
          cw_start      <= 1'b1;
          cw_buf_sel    <= cw_idx_reg[0];
          cw_spare_tx   <= cw_idx_reg[0] ? spare_buffer_b : spare_buffer_a; // R6
          cw_half_pad   <= half_sel(flash_control_reg, ecc_control_reg); // R18
          cw_page_bytes <= half_sel(flash_control_reg, ecc_control_reg) ?
                           11'h200 : 11'h400; // R17 R18
          // randomizer forced off with half codewords
          rand_active   <= rand_cfg_reg[`NCWT_RND_EN] & cw_master &
                           ~half_sel(flash_control_reg, ecc_control_reg); // R20
          state_reg     <= ST_WAIT;
        end
        ST_WAIT:
        begin
          if (cw_done)
          begin
            // cap keeps an oversized count inside the 32 status slots
            if (cw_idx_reg >= cw_total_reg || cw_idx_reg == 6'h1F)
            begin
              flash_control_reg[`NCWT_FL_DONE] <= 1'b1; // R11
              status_ready_reg <= 1'b1;
              state_reg <= ST_IDLE;
            end
            else
            begin
              cw_idx_reg <= cw_idx_reg + 6'h01;
              if (cw_master)
              begin
                cw_page_addr  <= cw_page_addr + page_stride(flash_control_reg); // R14 R13
                cw_spare_addr <= cw_spare_addr + spare_stride(flash_control_reg); // R15
              end
              state_reg <= ST_RUN;
            end
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
      if (ecc_valid && state_reg == ST_WAIT)
      begin
        cw_status_mem[cw_idx_reg[4:0]] <= ecc_status; // R4
        // status goes out next to spare when enabled
        cw_status_wr <= cw_master & flash_control_reg[`NCWT_FL_STXFER]; // R5
        if (!cw_master)
        begin
          // decode captures spare bytes into the buffer's register
          if (cw_idx_reg[0]) // R6
            spare_buffer_b <= {flash_data_in, flash_data_in, flash_data_in, flash_data_in};
          else
            spare_buffer_a <= {flash_data_in, flash_data_in, flash_data_in, flash_data_in};
        end
      end
    end
  end

  // flash pins idle in the deselected state; byte engine owns real cycles
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      chip_select0_n <= 1'b1;
      chip_select1_n <= 1'b1;
      flash_ale      <= 1'b0;
      flash_cle      <= 1'b0;
      flash_wrn      <= 1'b1;
      flash_rdn      <= 1'b1;
      flash_data_out <= 8'hFF;
      flash_data_oe  <= 1'b0;
      flash_dqs_out  <= 1'b0;
      flash_dqs_oe   <= 1'b0;
    end
    else
    begin
      // selects follow the sequencer, so the one picked by control bit 1 stays low between codewords
      chip_select0_n <= ~op_busy | flash_control_reg[1]; // R22
      chip_select1_n <= ~op_busy | ~flash_control_reg[1]; // R22
      flash_ale      <= 1'b0;
      flash_cle      <= 1'b0;
      flash_wrn      <= ~(cw_start & flash_rdy);
      flash_rdn      <= 1'b1;
      flash_data_out <= cw_spare_tx[7:0];
      flash_data_oe  <= cw_start & flash_rdy;
      // async byte interface never drives the strobe
      flash_dqs_out  <= 1'b0; // R22
      flash_dqs_oe   <= 1'b0;
    end
  end

  wire unused_ok = flash_dqs_in;

endmodule
`default_nettype wire

// >>> ncwt_core_sva.sv
// assertion checker for the codeword transfer block
`timescale 1ns/1ps
`default_nettype none
module ncwt_chk
(
  // apb
  input wire        pclk,
  input wire        presetn,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire        pready,
  input wire        pslverr,
  // engine and pins
  input wire        cw_start,
  input wire [10:0] cw_page_bytes,
  input wire [31:0] cw_page_addr,
  input wire        cw_master,
  input wire        rand_active,
  input wire        chip_select0_n,
  input wire        chip_select1_n,
  input wire        flash_dqs_oe
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  wire go = psel && penable && pready && pwrite && paddr == 12'h000 && pwdata[0];
  wire idle = chip_select0_n && chip_select1_n;
  logic        first;
  logic [31:0] last_pg;
  always @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      first <= 1'b1;
      last_pg <= 32'h0;
    end
    else if (go)
      first <= 1'b1;
    else if (cw_start)
    begin
      first <= 1'b0;
      last_pg <= cw_page_addr;
    end
  apb_wait_a: assert property ($rose(penable) && psel |-> !pready ##1 pready)
    else $error("pready not after one wait state");
  err_pair_a: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  start_lat_a: assert property (go && idle |-> ##[1:3] cw_start)
    else $error("no codeword start after start write");
  cw_pulse_a: assert property (cw_start |=> !cw_start)
    else $error("codeword start not a pulse");
  cs_busy_a: assert property (cw_start |-> !idle)
    else $error("no chip select during codeword");
  cs_one_a: assert property (!(!chip_select0_n && !chip_select1_n))
    else $error("both chip selects active");
  dqs_off_a: assert property (!flash_dqs_oe)
    else $error("strobe driven on byte interface");
  unit_size_a: assert property (cw_start |-> cw_page_bytes inside {11'h400, 11'h200})
    else $error("illegal codeword byte count");
  page_step_a: assert property (cw_start && !first && cw_master |->
    (cw_page_addr - last_pg) inside {32'h400, 32'h200})
    else $error("page address step wrong");
  rand_half_a: assert property (!(rand_active && cw_page_bytes == 11'h200))
    else $error("randomizer active in half codeword mode");
  cover property (go);
  cover property (pslverr);
  cover property (cw_start && !first);
endmodule
bind ncwt_core ncwt_chk i_ncwt_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
  .pwdata, .pready, .pslverr, .cw_start, .cw_page_bytes, .cw_page_addr, .cw_master, .rand_active,
  .chip_select0_n, .chip_select1_n, .flash_dqs_oe);
`default_nettype wire

// >>> ncwt_flash_model.sv
// far-side model: flash device plus byte engine answering each codeword
`timescale 1ns/1ps
`default_nettype none
module ncwt_flash_model
(
  // clock and control
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        cw_start,
  input  wire logic        chip_select0_n,
  input  wire logic        chip_select1_n,
  input  wire logic        slow,
  // results and pins
  output logic             ecc_valid,
  output logic [15:0]      ecc_status,
  output logic             seed_valid,
  output logic [1:0]       seed_err_cnt,
  output logic             seed_fail,
  output logic             seed_errf,
  output logic             cw_done,
  output logic [7:0]       flash_data,
  output logic             flash_rdy
);
  logic [3:0] cnt;
  logic [4:0] idx;
  logic       busy;
  assign seed_err_cnt = 2'h2;
  assign seed_fail = 1'b0;
  assign seed_errf = 1'b1;
  always @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      {ecc_valid, seed_valid, cw_done, busy} <= 4'h0;
      cnt <= 4'h0;
      idx <= 5'h0;
      ecc_status <= 16'h0;
      flash_data <= 8'hA5;
      flash_rdy <= 1'b1;
    end
    else
    begin
      {ecc_valid, seed_valid, cw_done} <= 3'h0;
      // released bus never shows a stale byte
      flash_data <= ~flash_data;
      flash_rdy <= !busy;
      if (chip_select0_n && chip_select1_n)
        idx <= 5'h0;
      if (cw_start)
      begin
        busy <= 1'b1;
        cnt <= slow ? 4'h8 : 4'h2;
      end
      else if (busy)
      begin
        cnt <= cnt - 4'h1;
        if (cnt == 4'h2)
        begin
          ecc_valid <= 1'b1;
          ecc_status <= 16'h0A50 + {11'h0, idx};
          seed_valid <= idx == 5'h0;
        end
        if (cnt == 4'h1)
        begin
          cw_done <= 1'b1;
          busy <= 1'b0;
          idx <= idx + 5'h1;
        end
      end
    end
endmodule
`default_nettype wire

// >>> ncwt_map.vh
// register offsets, field positions and constants of the codeword transfer block
`ifndef NCWT_MAP_VH
`define NCWT_MAP_VH
`define NCWT_OFF_FLASH_CONTROL_REG      12'h000
`define NCWT_OFF_ECC_CONTROL_REG     12'h004
`define NCWT_OFF_MTCFG      12'h008
`define NCWT_OFF_PAGE_ADDR  12'h00C
`define NCWT_OFF_SPARE_ADDR 12'h010
`define NCWT_OFF_CUR_PAGE   12'h014
`define NCWT_OFF_CUR_SPARE  12'h018
`define NCWT_OFF_BCHST0     12'h150
`define NCWT_OFF_BCHST15    12'h18C
`define NCWT_OFF_SPARE_A    12'h200
`define NCWT_OFF_SPARE_B    12'h204
`define NCWT_OFF_RAND_CFG   12'h208
`define NCWT_OFF_SEED_ST    12'h20C
`define NCWT_FL_START       0
`define NCWT_FL_CWN_LO      5
`define NCWT_FL_MANAGED     11
`define NCWT_FL_STXFER      19
`define NCWT_FL_DONE        20
`define NCWT_FL_HALF        21
`define NCWT_FL_MCWN_LO     22
`define NCWT_BCH_HALF       16
`define NCWT_MT_MASTER      2
`define NCWT_RND_EN         31
`define NCWT_SEED_RDY       5
`define NCWT_SEED_ERR_LO    3
`define NCWT_SEED_FAIL      2
`define NCWT_SEED_DONE      1
`define NCWT_SEED_ERRF      0
`define NCWT_BCHST_RDY      31
`define NCWT_UNIT_FULL      32'h0000_0400
`define NCWT_UNIT_HALF      32'h0000_0200
`define NCWT_SPARE_STRIDE_NARROW   32'h0000_0004
`define NCWT_SPARE_STRIDE_WIDE     32'h0000_0008
`define NCWT_SPARE_RESET    32'hFFFF_FFFF
`endif

// >>> tb.sv
// self-checking bench for the codeword transfer block
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, slow = 0, perr;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, prd;
  logic [31:0] pg [8], sp [8], tx [8];
  logic [10:0] by [8];
  logic        ms [8];
  logic [2:0]  fl [8];
  logic        clr = 0;
  logic [3:0]  k;
  logic [3:0]  cfg [4] = '{4'h0, 4'h7, 4'hA, 4'hC};
  int          mismatches = 0, checked = 0, ncw = 0, nsw = 0;
  wire [31:0]  prdata, cw_page_addr, cw_spare_addr, cw_spare_tx;
  wire [15:0]  ecc_status;
  wire [10:0]  cw_page_bytes;
  wire [7:0]   flash_data_in, fd_out, fm;
  wire [1:0]   seed_err_cnt;
  wire         pready, pslverr, ecc_valid, seed_valid, seed_fail, seed_errf, cw_done;
  wire         flash_rdy, chip_select0_n, chip_select1_n, flash_ale, flash_cle, flash_wrn;
  wire         flash_rdn, fd_oe, flash_dqs_oe, cw_start, cw_master, cw_status_wr, rand_active;
  wire         cw_half_pad, cw_buf_sel;
  assign flash_data_in = fd_oe ? fd_out : fm;
  ncwt_core i_ncwt_core (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .ecc_valid, .ecc_status, .seed_valid, .seed_err_cnt, .seed_fail,
    .seed_errf, .cw_done, .flash_data_in, .flash_dqs_in(1'b0), .flash_rdy, .chip_select0_n,
    .chip_select1_n, .flash_ale, .flash_cle, .flash_wrn, .flash_rdn, .flash_data_out(fd_out),
    .flash_data_oe(fd_oe), .flash_dqs_out(), .flash_dqs_oe, .cw_start, .cw_page_bytes,
    .cw_half_pad, .cw_page_addr, .cw_spare_addr, .cw_master, .cw_buf_sel, .cw_spare_tx,
    .cw_status_wr, .rand_active);
  ncwt_flash_model i_ncwt_flash_model (.pclk, .presetn, .cw_start, .chip_select0_n,
    .chip_select1_n, .slow, .ecc_valid, .ecc_status, .seed_valid, .seed_err_cnt, .seed_fail,
    .seed_errf, .cw_done, .flash_data(fm), .flash_rdy);
  initial forever #20 pclk = ~pclk;
  always @(posedge pclk)
  begin
    if (clr)
    begin
      ncw <= 0;
      nsw <= 0;
    end
    else
    begin
      if (cw_start === 1'b1 && ncw < 8)
      begin
        pg[ncw] <= cw_page_addr;
        sp[ncw] <= cw_spare_addr;
        tx[ncw] <= cw_spare_tx;
        by[ncw] <= cw_page_bytes;
        ms[ncw] <= cw_master;
        fl[ncw] <= {rand_active, cw_half_pad, cw_buf_sel};
        ncw <= ncw + 1;
      end
      if (cw_status_wr === 1'b1)
        nsw <= nsw + 1;
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic summarize;
    if (mismatches == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // one idle edge first, so psel never changes twice in a time step
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    if (n >= 20)
    begin
      mismatches++;
      summarize();
    end
    prd = prdata;
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rdc(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(prd, e);
  endtask
  task automatic wait_done;
    int n;
    n = 0;
    do
    begin
      apb(1'b0, 12'h000, 32'h0);
      n++;
    end
    while (prd[20] !== 1'b1 && n < 60);
    if (n >= 60)
    begin
      mismatches++;
      summarize();
    end
  endtask
  initial
  begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    chk({chip_select0_n, chip_select1_n, flash_wrn, flash_rdn, flash_ale, flash_cle}, 6'h3C);
    rdc(12'h20C, 32'h0);
    rdc(12'h150, 32'h0);
    rdc(12'h0FC, 32'h0);
    chk(perr, 1'b1);
    // table bits: managed, half select, ecc half, status transfer
    for (int c = 0; c < 4; c++)
    begin
      k = cfg[c];
      wr(12'h208, {k == 4'hC || k == 4'h0, 31'h0});
      wr(12'h004, {15'h0, k[1], 16'h0});
      wr(12'h008, 32'h4);
      wr(12'h00C, 32'h1000_0000);
      wr(12'h010, 32'h2000_0000);
      clr <= 1'b1;
      @(posedge pclk);
      clr <= 1'b0;
      wr(12'h000, {4'h0, 6'h03, k[2], 1'b0, k[0], 7'h00, k[3], 11'h001});
      wait_done;
      chk(ncw, 3);
      chk(nsw, k[0] ? 3 : 0);
      for (int i = 0; i < 3; i++)
      begin
        chk(pg[i], 32'h1000_0000 + i * ((k[3] & k[2]) ? 32'h200 : 32'h400));
        chk(sp[i], 32'h2000_0000 + i * (k[0] ? 32'h8 : 32'h4));
        chk(by[i], (k[3] ? k[2] : k[1]) ? 11'h200 : 11'h400);
        chk(ms[i], 1'b1);
        chk(fl[i], {k == 4'h0, (k[3] ? k[2] : k[1]), i[0]});
      end
    end
    wr(12'h208, 32'h0);
    wr(12'h004, 32'h0);
    wr(12'h008, 32'h0);
    wr(12'h200, 32'h1122_3344);
    wr(12'h204, 32'h5566_7788);
    slow <= 1'b1;
    clr <= 1'b1;
    @(posedge pclk);
    clr <= 1'b0;
    wr(12'h000, 32'h0000_0061);
    apb(1'b0, 12'h000, 32'h0);
    chk(prd[20], 1'b0);
    wait_done;
    chk(ncw, 2);
    chk(tx[0], 32'h1122_3344);
    chk(tx[1], 32'h5566_7788);
    chk(ms[0], 1'b0);
    chk(fl[1], 3'h1);
    rdc(12'h150, 32'h8A51_0A50);
    rdc(12'h154, 32'h0000_0A52);
    rdc(12'h20C, 32'h33);
    summarize();
  end
endmodule
`default_nettype wire
